/* src/csiu_consts.vh */
// register offsets, field positions and reset values of the clock status interrupt unit
`ifndef CSIU_CONSTS_VH
`define CSIU_CONSTS_VH
`define CSIU_ADDR_LOSS_IE 8'h68
`define CSIU_ADDR_REFHOLD_IE 8'h69
`define CSIU_ADDR_LOSS_LATCH 8'h6c
`define CSIU_ADDR_LIVE_SEL 8'h6d
`define CSIU_ADDR_REFHOLD_LATCH 8'h6e
`define CSIU_ADDR_REFHOLD_LIVE 8'h6f
`define CSIU_BIT_SYNTH 5
`define CSIU_BIT_VCXO 4
`define CSIU_BIT_HOLD 0
`define CSIU_BIT_REF 1
`define CSIU_BIT_CAL 2
`define CSIU_IE_RESET 8'h00
`define CSIU_LATCH_RESET 1'b1
`define CSIU_REFHOLD_IE_RESET 2'h0
`define CSIU_LIVE_RESET 8'h3f
`define CSIU_REFHOLD_LIVE_RESET 3'h3
`define CSIU_RDATA_RESET 8'h00
`define CSIU_IRQ_IDLE 1'b1
`endif

/* src/csiu_latch.v */
// one sticky event latch: reads 1 with no event, 0 after an event, write 1 clears
`timescale 1ns/1ns
`include "csiu_consts.vh"
module csiu_latch (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // event and clear
  input wire event_in,
  input wire clear_in,
  // state
  output reg state_reg
);
  // set wins over clear so an event in the clearing cycle is kept
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= `CSIU_LATCH_RESET;
    end else if (event_in) begin
      state_reg <= 1'b0;
    end else if (clear_in) begin
      state_reg <= 1'b1;
    end
  end
endmodule

/* src/csiu_top.v */
// status latches, interrupt enables and interrupt output of the clock status unit
`timescale 1ns/1ns
`include "csiu_consts.vh"
module csiu_top (
  // clock and reset
  input wire clock,
  input wire nrst,
  // register port from the serial configuration logic
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // live status from detectors and selection logic
  input wire synth_pll_lock_live_n,
  input wire vcxo_pll_lock_live_n,
  input wire [3:0] input_active_live,
  input wire [1:0] selected_input_code,
  input wire reference_present_live,
  input wire holdover_live_n,
  input wire synth_calibration_active,
  // interrupt
  output reg irq_out_n
);

  // reset synchroniser
  reg rst_s1_reg;
  reg rst_n_reg;

  // enables
  reg [7:0] loss_ie_reg;
  reg [1:0] refhold_ie_reg;

  // live snapshot and edge memory
  reg [7:0] live_reg;
  reg [2:0] refhold_live_reg;
  reg ref_prev_reg;

  // latched flags, 1 means no event since the last clear
  wire synth_pll_lock_latched_n;
  wire vcxo_pll_lock_latched_n;
  wire [3:0] input_active_latched;
  wire reference_valid_latched;
  wire holdover_latched_n;

  // enable fields
  wire [3:0] input_loss_irq_en;
  wire synth_pll_unlock_irq_en;
  wire vcxo_pll_unlock_irq_en;
  wire reference_irq_en;
  wire holdover_irq_en;

  // write strobes per register
  wire wr_loss_ie;
  wire wr_refhold_ie;
  wire wr_loss;
  wire wr_refhold;

  // events seen by the latches
  wire ev_synth;
  wire ev_vcxo;
  wire [3:0] ev_input;
  wire ev_ref;
  wire ev_hold;

  // write-one clears
  wire clr_synth;
  wire clr_vcxo;
  wire [3:0] clr_input;
  wire clr_ref;
  wire clr_hold;

  // enabled pending sources
  wire pend_synth;
  wire pend_vcxo;
  wire pend_input;
  wire pend_ref;
  wire pend_hold;
  wire irq_next;

  // read bytes
  wire [7:0] loss_ie_byte;
  wire [7:0] refhold_ie_byte;
  wire [7:0] loss_latch_byte;
  wire [7:0] refhold_latch_byte;
  wire [7:0] refhold_live_byte;
  reg [7:0] rdata_next;

  // nrst takes effect at once but is released through two flops
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  // writes to read-only or unmapped addresses match no strobe and are dropped
  assign wr_loss_ie = reg_wr && (reg_addr == `CSIU_ADDR_LOSS_IE);
  assign wr_refhold_ie = reg_wr && (reg_addr == `CSIU_ADDR_REFHOLD_IE);
  assign wr_loss = reg_wr && (reg_addr == `CSIU_ADDR_LOSS_LATCH);
  assign wr_refhold = reg_wr && (reg_addr == `CSIU_ADDR_REFHOLD_LATCH);

  // reserved enable bits are not stored, so they read back as zero
  always @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      loss_ie_reg <= `CSIU_IE_RESET;
    end else if (wr_loss_ie) begin
      loss_ie_reg <= {2'h0, reg_wdata[5:0]};
    end
  end

  always @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      refhold_ie_reg <= `CSIU_REFHOLD_IE_RESET;
    end else if (wr_refhold_ie) begin
      refhold_ie_reg <= reg_wdata[1:0];
    end
  end

  assign synth_pll_unlock_irq_en = loss_ie_reg[`CSIU_BIT_SYNTH];
  assign vcxo_pll_unlock_irq_en = loss_ie_reg[`CSIU_BIT_VCXO];
  assign input_loss_irq_en = loss_ie_reg[3:0];
  assign reference_irq_en = refhold_ie_reg[`CSIU_BIT_REF];
  assign holdover_irq_en = refhold_ie_reg[`CSIU_BIT_HOLD];

  // live snapshot; registered so reads and latches see one consistent sample
  always @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      live_reg <= `CSIU_LIVE_RESET;
    end else begin
      live_reg <= {selected_input_code, synth_pll_lock_live_n, vcxo_pll_lock_live_n,
        input_active_live};
    end
  end

  always @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      refhold_live_reg <= `CSIU_REFHOLD_LIVE_RESET;
    end else begin
      refhold_live_reg <= {synth_calibration_active, reference_present_live,
        holdover_live_n};
    end
  end

  // presence resets to 1, its idle level, so no false drop follows reset
  always @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ref_prev_reg <= 1'b1;
    end else begin
      ref_prev_reg <= refhold_live_reg[`CSIU_BIT_REF];
    end
  end

  // loss and holdover are levels; reference loss is a falling edge of presence
  assign ev_synth = ~live_reg[`CSIU_BIT_SYNTH];
  assign ev_vcxo = ~live_reg[`CSIU_BIT_VCXO];
  assign ev_input = ~live_reg[3:0];
  assign ev_ref = ref_prev_reg & ~refhold_live_reg[`CSIU_BIT_REF];
  assign ev_hold = ~refhold_live_reg[`CSIU_BIT_HOLD];

  assign clr_synth = wr_loss & reg_wdata[`CSIU_BIT_SYNTH];
  assign clr_vcxo = wr_loss & reg_wdata[`CSIU_BIT_VCXO];
  assign clr_input = {4{wr_loss}} & reg_wdata[3:0];
  assign clr_ref = wr_refhold & reg_wdata[`CSIU_BIT_REF];
  assign clr_hold = wr_refhold & reg_wdata[`CSIU_BIT_HOLD];

  csiu_latch u_synth (
    .clock(clock),
    .rst_n(rst_n_reg),
    .event_in(ev_synth),
    .clear_in(clr_synth),
    .state_reg(synth_pll_lock_latched_n)
  );

  csiu_latch u_vcxo (
    .clock(clock),
    .rst_n(rst_n_reg),
    .event_in(ev_vcxo),
    .clear_in(clr_vcxo),
    .state_reg(vcxo_pll_lock_latched_n)
  );

  csiu_latch u_in0 (
    .clock(clock),
    .rst_n(rst_n_reg),
    .event_in(ev_input[0]),
    .clear_in(clr_input[0]),
    .state_reg(input_active_latched[0])
  );

  csiu_latch u_in1 (
    .clock(clock),
    .rst_n(rst_n_reg),
    .event_in(ev_input[1]),
    .clear_in(clr_input[1]),
    .state_reg(input_active_latched[1])
  );

  csiu_latch u_in2 (
    .clock(clock),
    .rst_n(rst_n_reg),
    .event_in(ev_input[2]),
    .clear_in(clr_input[2]),
    .state_reg(input_active_latched[2])
  );

  csiu_latch u_in3 (
    .clock(clock),
    .rst_n(rst_n_reg),
    .event_in(ev_input[3]),
    .clear_in(clr_input[3]),
    .state_reg(input_active_latched[3])
  );

  // a reference lost before reset release is seen as a drop from the reset value 1
  // and is reported just after release
  csiu_latch u_ref (
    .clock(clock),
    .rst_n(rst_n_reg),
    .event_in(ev_ref),
    .clear_in(clr_ref),
    .state_reg(reference_valid_latched)
  );

  csiu_latch u_hold (
    .clock(clock),
    .rst_n(rst_n_reg),
    .event_in(ev_hold),
    .clear_in(clr_hold),
    .state_reg(holdover_latched_n)
  );

  assign pend_synth = synth_pll_unlock_irq_en & ~synth_pll_lock_latched_n;
  assign pend_vcxo = vcxo_pll_unlock_irq_en & ~vcxo_pll_lock_latched_n;
  assign pend_input = |(input_loss_irq_en & ~input_active_latched);
  assign pend_ref = reference_irq_en & ~reference_valid_latched;
  assign pend_hold = holdover_irq_en & ~holdover_latched_n;
  assign irq_next = ~(pend_synth | pend_vcxo | pend_input | pend_ref | pend_hold);

  // reserved bits read as zero
  assign loss_ie_byte = loss_ie_reg;
  assign refhold_ie_byte = {6'h00, refhold_ie_reg};
  assign loss_latch_byte = {2'h0, synth_pll_lock_latched_n, vcxo_pll_lock_latched_n,
    input_active_latched};
  assign refhold_latch_byte = {6'h00, reference_valid_latched, holdover_latched_n};
  assign refhold_live_byte = {5'h00, refhold_live_reg};

  always @* begin
    rdata_next = 8'h00;
    case (reg_addr)
      `CSIU_ADDR_LOSS_IE: rdata_next = loss_ie_byte;
      `CSIU_ADDR_REFHOLD_IE: rdata_next = refhold_ie_byte;
      `CSIU_ADDR_LOSS_LATCH: rdata_next = loss_latch_byte;
      `CSIU_ADDR_LIVE_SEL: rdata_next = live_reg;
      `CSIU_ADDR_REFHOLD_LATCH: rdata_next = refhold_latch_byte;
      `CSIU_ADDR_REFHOLD_LIVE: rdata_next = refhold_live_byte;
      default: rdata_next = 8'h00;
    endcase
  end

  // read data holds until the next read strobe
  always @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      reg_rdata <= `CSIU_RDATA_RESET;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // registered so the pin never glitches while several latches change at once
  always @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      irq_out_n <= `CSIU_IRQ_IDLE;
    end else begin
      irq_out_n <= irq_next;
    end
  end
endmodule

/* testbench/csiu_top_assertions.sv */
// port checks for the clock status unit
`timescale 1ns/1ns
module csiu_top_checker (
  // clock and reset
  input wire clock,
  input wire nrst,
  // register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // status
  input wire synth_pll_lock_live_n,
  input wire vcxo_pll_lock_live_n,
  input wire [3:0] input_active_live,
  input wire [1:0] selected_input_code,
  input wire reference_present_live,
  input wire holdover_live_n,
  input wire synth_calibration_active,
  // interrupt
  input wire irq_out_n
);
  // shadow of both enable bytes
  reg [15:0] en_reg;
  always @(posedge clock or negedge nrst)
    if (!nrst)
      en_reg <= 16'h0000;
    else if (reg_wr && reg_addr == 8'h68)
      en_reg[7:0] <= reg_wdata;
    else if (reg_wr && reg_addr == 8'h69)
      en_reg[15:8] <= reg_wdata;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_rd(a); reg_rd && reg_addr == a; endsequence
  a_irq_reset: assert property (disable iff (1'b0) !nrst |=> irq_out_n)
    else $error("irq in reset");
  a_sel_code: assert property (s_rd(8'h6d) |=>
    reg_rdata[7:6] == $past(selected_input_code, 2)) else $error("sel");
  a_live_loss: assert property (s_rd(8'h6d) |=> reg_rdata[5:0] ==
    $past({synth_pll_lock_live_n, vcxo_pll_lock_live_n, input_active_live}, 2))
    else $error("live");
  a_synth_irq: assert property ((!synth_pll_lock_live_n && en_reg[5])[*3] |=>
    !irq_out_n) else $error("synth irq");
  a_input_irq: assert property ((!input_active_live[0] && en_reg[0])[*3] |=>
    !irq_out_n) else $error("input irq");
  a_hold_irq: assert property ((!holdover_live_n && en_reg[8])[*3] |=>
    !irq_out_n) else $error("hold irq");
  a_irq_off: assert property ((en_reg[5:0] == 6'h00 && en_reg[9:8] == 2'h0)[*2] |=>
    irq_out_n) else $error("irq off");
  a_synth_latch: assert property (s_rd(8'h6c) ##0 $past(!synth_pll_lock_live_n, 2) |=>
    !reg_rdata[5]) else $error("latch");
endmodule
bind csiu_top csiu_top_checker i_csiu_top_checker (.clock, .nrst, .reg_addr, .reg_wr,
  .reg_wdata, .reg_rd, .reg_rdata, .synth_pll_lock_live_n, .vcxo_pll_lock_live_n,
  .input_active_live, .selected_input_code, .reference_present_live, .holdover_live_n,
  .synth_calibration_active, .irq_out_n);

/* testbench/csiu_host.sv */
// host model on the register port
`timescale 1ns/1ns
module csiu_host (
  // clock
  input wire clock,
  // register port
  output logic [7:0] reg_addr = 8'h00,
  output logic reg_wr = 1'b0,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_rd = 1'b0,
  input wire [7:0] reg_rdata
);
  // one strobe cycle; released data is inverted so stale values never match
  task acc(input w, input [7:0] a, input [7:0] d, output [7:0] q);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    {reg_wr, reg_rd} = {w, !w};
    @(negedge clock);
    {reg_wr, reg_rd} = 2'b00;
    reg_wdata = ~d;
    q = reg_rdata;
  endtask
endmodule

/* testbench/tb_csiu_top.sv */
// bench for the clock status unit
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected %0t %h %h", $time, a, e); end end
module tb_csiu_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] st = 8'hff, d, m, en, la, lb;
  logic [1:0] sel = 2'b00;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, irq_out_n;
  int n_errors = 0, n_compared = 0;
  csiu_host i_csiu_host (.clock, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
  csiu_top i_csiu_top (.clock, .nrst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .synth_pll_lock_live_n(st[5]), .vcxo_pll_lock_live_n(st[4]), .input_active_live(st[3:0]),
    .selected_input_code(sel), .reference_present_live(st[6]), .holdover_live_n(st[7]),
    .synth_calibration_active(1'b0), .irq_out_n);
  task rd(input [7:0] a, input [7:0] e);
    i_csiu_host.acc(1'b0, a, 8'h00, d);
    `CHK(d, e)
  endtask
  task wr(input [7:0] a, input [7:0] v);
    i_csiu_host.acc(1'b1, a, v, d);
  endtask
  task print_verdict;
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial forever #2 clock = ~clock;
  initial begin
    #20000;
    n_errors++;
    print_verdict;
  end
  initial begin
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    repeat (3) @(negedge clock);
    rd(8'h68, 8'h00);
    rd(8'h69, 8'h00);
    rd(8'h6c, 8'h3f);
    rd(8'h6e, 8'h03);
    rd(8'h6a, 8'h00);
    wr(8'h6d, 8'h00);
    for (int i = 0; i < 4; i++) begin
      sel = i[1:0];
      rd(8'h6d, {sel, 6'h3f});
    end
    // one pass per source: inputs, vcxo, synth, reference, holdover
    for (int j = 0; j < 8; j++) begin
      m = (j < 6) ? 8'h01 << j : 8'h01 << (7 - j);
      en = (j < 6) ? 8'h68 : 8'h69;
      la = (j < 6) ? 8'h6c : 8'h6e;
      lb = (j < 6) ? 8'h3f : 8'h03;
      st[j] = 1'b0;
      repeat (4) @(negedge clock);
      `CHK(irq_out_n, 1'b1)
      rd(la + 8'h01, ((j < 6) ? 8'hff : 8'h03) & ~m);
      wr(en, m);
      repeat (3) @(negedge clock);
      `CHK(irq_out_n, 1'b0)
      rd(la, lb & ~m);
      st[j] = 1'b1;
      wr(la, m);
      repeat (3) @(negedge clock);
      `CHK(irq_out_n, 1'b1)
      rd(la, lb);
      wr(en, 8'h00);
    end
    print_verdict;
  end
endmodule
